//--- include/misc_ctrl_pkg.sv
// Constants, register map and carrier types for the misc control bank.
// Assumes one 20 MHz clock, which is the internal oscillator clock.
package misc_ctrl_pkg;

    localparam int unsigned CLOCK_HZ = 20_000_000;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h20;
    localparam logic [7:0] IDX_TIMER_SETUP = 8'h21;
    localparam logic [7:0] IDX_BUFFER_CONFIG = 8'h30;
    localparam logic [7:0] IDX_POWER = 8'h31;
    localparam logic [7:0] IDX_OSCILLATOR = 8'h32;
    localparam logic [7:0] IDX_EXCITATION = 8'h33;
    localparam logic [7:0] IDX_PIN_ONE = 8'h40;
    localparam logic [7:0] IDX_PIN_TWO = 8'h41;

    localparam logic [15:0] REG_RESET = 16'h0000;

    // Timer control fields
    localparam int TIMER_DONE_BIT = 15;
    localparam int TIMER_RUN_BIT = 14;
    localparam int HALT_ENABLE_BIT = 0;
    // Timer setup fields
    localparam int PRESCALE_MSB = 15;
    localparam int PRESCALE_LSB = 12;
    localparam int TIMEOUT_MSB = 11;
    localparam int TIMEOUT_LSB = 0;
    localparam logic [8:0] PRESCALE_EVEN_BASE = 9'h001;
    localparam logic [8:0] PRESCALE_ODD_BASE = 9'h003;

    // Pin control fields
    localparam int PIN_OUT_BIT = 5;
    localparam int PIN_DRIVE_BIT = 4;
    localparam int PIN_IN_BIT = 3;
    localparam int PIN_CLEAR_BIT = 2;
    localparam int PIN_INVERT_BIT = 1;
    localparam int PIN_EDGE_BIT = 0;

    // Writable bit masks; the rest reads as zero
    localparam logic [15:0] BUFFER_MASK = 16'h0003;
    localparam logic [15:0] POWER_MASK = 16'h1133;
    localparam logic [15:0] OSC_MASK = 16'h1F01;
    localparam logic [15:0] EXCITATION_MASK = 16'h0007;

    localparam int POWER_FLASH_BIT = 12;
    localparam int POWER_ADC_BIT = 8;
    localparam int POWER_DAC_TWO_BIT = 5;
    localparam int POWER_DAC_ONE_BIT = 4;
    localparam int POWER_AMP_TWO_BIT = 1;
    localparam int POWER_AMP_ONE_BIT = 0;
    localparam int TRIM_MSB = 12;
    localparam int TRIM_LSB = 8;
    localparam int CLOCK_OUT_BIT = 0;

    // Pin must hold steady this many oscillator periods
    localparam int FILTER_PERIODS = 4;
    localparam logic [1:0] FILTER_LAST = 2'(FILTER_PERIODS - 1);

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic flashProgramPower;
        logic converterInPower;
        logic dacTwoPower;
        logic dacOnePower;
        logic ampTwoPower;
        logic ampOnePower;
        logic channelTwoBufferMode;
        logic channelOneBufferMode;
        logic [2:0] excitationCurrentCode;
        logic signed [4:0] oscillatorTrim;
    } analog_ctrl_t;

endpackage

//--- core/misc_peripheral_control_regs.sv
// Misc control bank: general pins, interval timer, analog power and trim.
// Assumes an APB master on the same clock; pins and the clock select
// strap arrive asynchronously, dacEnable comes from logic on this clock.
`timescale 1ns/10ps

module misc_peripheral_control_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire misc_ctrl_pkg::apb_req_t apbReq,
    output misc_ctrl_pkg::apb_rsp_t apbRsp,
    input wire logic [1:0] generalPinIn,
    output logic [1:0] generalPinOut,
    output logic [1:0] generalPinOe_n,
    input wire logic [1:0] dacEnable,
    input wire logic clockSourceSelectPin,
    output logic clockPinOe_n,
    output logic oscillatorHalt,
    output logic cpuHalt,
    output misc_ctrl_pkg::analog_ctrl_t analogCtrl
);
    import misc_ctrl_pkg::*;

    function automatic logic [8:0] prescale_ratio(input logic [3:0] code);
        logic [8:0] base;
        base = code[0] ? PRESCALE_ODD_BASE : PRESCALE_EVEN_BASE;
        return 9'(base << code[3:1]);
    endfunction

    // Bus and register state
    apb_rsp_t rsp_q, rsp_d;
    logic [15:0] buffer_q, buffer_d, power_q, power_d, osc_q, osc_d;
    logic [15:0] excite_q, excite_d, setup_q, setup_d;
    logic haltEnable_q, haltEnable_d, timerRun_q, timerRun_d;
    logic timerDone_q, timerDone_d;
    logic [8:0] tickCount_q, tickCount_d;
    logic [11:0] stepCount_q, stepCount_d;
    logic [5:0] pinCfg_q [2];
    logic [5:0] pinCfg_d [2];

    // Pin capture state
    logic [1:0] pinMeta_q, pinSync_q, filtLevel_q, filtLevel_d;
    logic [1:0] pinIn_q, pinIn_d;
    logic [1:0] filtCount_q [2];
    logic [1:0] filtCount_d [2];
    logic strapMeta_q, strapSync_q;

    // Output flops
    analog_ctrl_t analog_q, analog_d;
    logic [1:0] pinOut_q, pinOut_d, pinOe_n_q, pinOe_n_d;
    logic cpuHalt_q, cpuHalt_d, clockOe_n_q, clockOe_n_d;
    logic oscHalt_q, oscHalt_d;

    logic access, mapped, doWrite;
    logic [7:0] index;
    logic [15:0] readValue, wdata;
    logic startTimer;

    assign index = apbReq.paddr[9:2];
    assign access = apbReq.psel && apbReq.penable;
    assign doWrite = access && apbReq.pwrite && rsp_q.pready;
    assign wdata = apbReq.pwdata[15:0];

    always_comb begin
        mapped = apbReq.paddr[11:10] == 2'b00;
        readValue = 16'h0000;
        unique case (index)
            IDX_TIMER_CONTROL: begin
                readValue[TIMER_DONE_BIT] = timerDone_q;
                readValue[TIMER_RUN_BIT] = timerRun_q;
                readValue[HALT_ENABLE_BIT] = haltEnable_q;
            end
            IDX_TIMER_SETUP: readValue = setup_q;
            IDX_BUFFER_CONFIG: readValue = buffer_q;
            IDX_POWER: readValue = power_q;
            IDX_OSCILLATOR: readValue = osc_q;
            IDX_EXCITATION: readValue = excite_q;
            IDX_PIN_ONE: readValue = {10'h000, pinCfg_q[0]};
            IDX_PIN_TWO: readValue = {10'h000, pinCfg_q[1]};
            default: mapped = 1'b0;
        endcase
        if (mapped && (index == IDX_PIN_ONE || index == IDX_PIN_TWO)) begin
            readValue[PIN_IN_BIT] = pinIn_q[index[0]];
        end
    end

    // Register writes and interval timer
    always_comb begin
        rsp_d.pready = access && !rsp_q.pready;
        rsp_d.prdata = rsp_q.prdata;
        rsp_d.pslverr = rsp_q.pslverr;
        if (access && !rsp_q.pready) begin
            rsp_d.prdata = {16'h0000, mapped ? readValue : 16'h0000};
            rsp_d.pslverr = !mapped;
        end
        buffer_d = buffer_q;
        power_d = power_q;
        osc_d = osc_q;
        excite_d = excite_q;
        setup_d = setup_q;
        haltEnable_d = haltEnable_q;
        pinCfg_d = pinCfg_q;
        startTimer = 1'b0;
        if (doWrite && mapped) begin
            unique case (index)
                IDX_TIMER_CONTROL: begin
                    haltEnable_d = wdata[HALT_ENABLE_BIT];
                    startTimer = wdata[TIMER_RUN_BIT];
                end
                IDX_TIMER_SETUP: setup_d = wdata;
                IDX_BUFFER_CONFIG: buffer_d = wdata & BUFFER_MASK;
                IDX_POWER: power_d = wdata & POWER_MASK;
                IDX_OSCILLATOR: osc_d = wdata & OSC_MASK;
                IDX_EXCITATION: excite_d = wdata & EXCITATION_MASK;
                IDX_PIN_ONE: pinCfg_d[0] = wdata[5:0];
                IDX_PIN_TWO: pinCfg_d[1] = wdata[5:0];
                default: ;
            endcase
        end
        timerRun_d = timerRun_q;
        timerDone_d = timerDone_q;
        tickCount_d = tickCount_q;
        stepCount_d = stepCount_q;
        // A restart written in the finishing cycle begins a fresh interval
        if (startTimer) begin
            timerRun_d = 1'b1;
            timerDone_d = 1'b0;
            tickCount_d = 9'h000;
            stepCount_d = 12'h000;
        end else if (timerRun_q) begin
            if (tickCount_q == 9'(prescale_ratio(
                    setup_q[PRESCALE_MSB:PRESCALE_LSB]) - 9'h001)) begin
                tickCount_d = 9'h000;
                stepCount_d = 12'(stepCount_q + 12'h001);
                if (stepCount_d >= setup_q[TIMEOUT_MSB:TIMEOUT_LSB]) begin
                    timerRun_d = 1'b0;
                    timerDone_d = 1'b1;
                end
            end else begin
                tickCount_d = 9'(tickCount_q + 9'h001);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rsp_q <= '0;
            buffer_q <= REG_RESET;
            power_q <= REG_RESET;
            osc_q <= REG_RESET;
            excite_q <= REG_RESET;
            setup_q <= REG_RESET;
            haltEnable_q <= 1'b0;
            timerRun_q <= 1'b0;
            timerDone_q <= 1'b0;
            tickCount_q <= 9'h000;
            stepCount_q <= 12'h000;
            pinCfg_q[0] <= 6'h00;
            pinCfg_q[1] <= 6'h00;
        end else if (clockEnable) begin
            rsp_q <= rsp_d;
            buffer_q <= buffer_d;
            power_q <= power_d;
            osc_q <= osc_d;
            excite_q <= excite_d;
            setup_q <= setup_d;
            haltEnable_q <= haltEnable_d;
            timerRun_q <= timerRun_d;
            timerDone_q <= timerDone_d;
            tickCount_q <= tickCount_d;
            stepCount_q <= stepCount_d;
            pinCfg_q <= pinCfg_d;
        end
    end

    // Pin filtering and capture
    always_comb begin
        logic [5:0] cfg;
        logic edgeSeen;
        cfg = 6'h00;
        edgeSeen = 1'b0;
        filtLevel_d = filtLevel_q;
        pinIn_d = pinIn_q;
        filtCount_d = filtCount_q;
        for (int i = 0; i < 2; i++) begin
            cfg = pinCfg_q[i];
            edgeSeen = 1'b0;
            if (pinSync_q[i] == filtLevel_q[i]) begin
                filtCount_d[i] = 2'b00;
            end else if (filtCount_q[i] == FILTER_LAST) begin
                filtCount_d[i] = 2'b00;
                filtLevel_d[i] = pinSync_q[i];
                edgeSeen = pinSync_q[i] != cfg[PIN_INVERT_BIT];
            end else begin
                filtCount_d[i] = 2'(filtCount_q[i] + 2'b01);
            end
            // Clear wins over any capture in the same cycle
            if (cfg[PIN_CLEAR_BIT]) begin
                pinIn_d[i] = 1'b0;
            end else if (cfg[PIN_EDGE_BIT]) begin
                pinIn_d[i] = pinIn_q[i] | edgeSeen;
            end else begin
                pinIn_d[i] = filtLevel_q[i] ^ cfg[PIN_INVERT_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pinMeta_q <= 2'b00;
            pinSync_q <= 2'b00;
            filtLevel_q <= 2'b00;
            pinIn_q <= 2'b00;
            filtCount_q[0] <= 2'b00;
            filtCount_q[1] <= 2'b00;
            strapMeta_q <= 1'b0;
            strapSync_q <= 1'b0;
        end else if (clockEnable) begin
            pinMeta_q <= generalPinIn;
            pinSync_q <= pinMeta_q;
            filtLevel_q <= filtLevel_d;
            pinIn_q <= pinIn_d;
            filtCount_q <= filtCount_d;
            strapMeta_q <= clockSourceSelectPin;
            strapSync_q <= strapMeta_q;
        end
    end

    // Output stage, one flop behind the registers
    always_comb begin
        analog_d.flashProgramPower = power_q[POWER_FLASH_BIT];
        analog_d.converterInPower = power_q[POWER_ADC_BIT];
        analog_d.dacTwoPower = power_q[POWER_DAC_TWO_BIT];
        analog_d.dacOnePower = power_q[POWER_DAC_ONE_BIT];
        analog_d.ampTwoPower = power_q[POWER_AMP_TWO_BIT] | dacEnable[1];
        analog_d.ampOnePower = power_q[POWER_AMP_ONE_BIT] | dacEnable[0];
        analog_d.channelTwoBufferMode = buffer_q[1] | dacEnable[1];
        analog_d.channelOneBufferMode = buffer_q[0] | dacEnable[0];
        analog_d.excitationCurrentCode = excite_q[2:0];
        analog_d.oscillatorTrim = signed'(osc_q[TRIM_MSB:TRIM_LSB]);
        for (int i = 0; i < 2; i++) begin
            pinOut_d[i] = pinCfg_q[i][PIN_OUT_BIT];
            pinOe_n_d[i] = !pinCfg_q[i][PIN_DRIVE_BIT];
        end
        cpuHalt_d = timerRun_q && haltEnable_q;
        clockOe_n_d = !(osc_q[CLOCK_OUT_BIT] && strapSync_q);
        oscHalt_d = !strapSync_q;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            analog_q <= '0;
            pinOut_q <= 2'b00;
            pinOe_n_q <= 2'b11;
            cpuHalt_q <= 1'b0;
            clockOe_n_q <= 1'b1;
            oscHalt_q <= 1'b0;
        end else if (clockEnable) begin
            analog_q <= analog_d;
            pinOut_q <= pinOut_d;
            pinOe_n_q <= pinOe_n_d;
            cpuHalt_q <= cpuHalt_d;
            clockOe_n_q <= clockOe_n_d;
            oscHalt_q <= oscHalt_d;
        end
    end

    assign apbRsp = rsp_q;
    assign analogCtrl = analog_q;
    assign generalPinOut = pinOut_q;
    assign generalPinOe_n = pinOe_n_q;
    assign cpuHalt = cpuHalt_q;
    assign clockPinOe_n = clockOe_n_q;
    assign oscillatorHalt = oscHalt_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_drive_follows_enable: assert property (
        clockEnable |=> generalPinOe_n[0] == !$past(pinCfg_q[0][PIN_DRIVE_BIT]))
        else $error("pin one drive enable not followed");
    a_level_tracks_pin: assert property (
        clockEnable && !pinCfg_q[1][PIN_EDGE_BIT] && !pinCfg_q[1][PIN_CLEAR_BIT]
        |=> pinIn_q[1] == ($past(filtLevel_q[1]) ^ $past(pinCfg_q[1][1])))
        else $error("level mode input bit wrong");
    a_edge_bit_sticky: assert property (
        pinCfg_q[0][PIN_EDGE_BIT] && !pinCfg_q[0][PIN_CLEAR_BIT] && pinIn_q[0]
        |=> pinIn_q[0])
        else $error("captured edge lost");
    a_clear_forces_zero: assert property (
        clockEnable && pinCfg_q[0][PIN_CLEAR_BIT] |=> !pinIn_q[0])
        else $error("clear did not force zero");
    a_filter_four_periods: assert property (
        $rose(filtLevel_q[0]) |-> $past(pinSync_q[0], 1)
            && $past(pinSync_q[0], 2) && $past(pinSync_q[0], 3)
            && $past(pinSync_q[0], 4))
        else $error("pin accepted before four stable periods");
    a_start_clears_done: assert property (
        clockEnable && startTimer |=> timerRun_q && !timerDone_q)
        else $error("timer start not taken");
    a_finish_sets_done: assert property (
        $fell(timerRun_q) |-> timerDone_q)
        else $error("timer stopped without done");
    a_halt_tracks_run: assert property (
        clockEnable |=> cpuHalt == ($past(timerRun_q) && $past(haltEnable_q)))
        else $error("cpu halt mismatch");
    a_dac_forces_buffer: assert property (
        clockEnable && dacEnable[1] |=> analogCtrl.ampTwoPower
            && analogCtrl.channelTwoBufferMode)
        else $error("dac two did not force amplifiers");
    a_unused_reads_zero: assert property (
        apbRsp.pready |-> apbRsp.prdata[31:16] == 16'h0000)
        else $error("unused read bits not zero");

    c_timer_done: cover property (clockEnable && $rose(timerDone_q));
    c_edge_capture: cover property (pinCfg_q[1][PIN_EDGE_BIT] && $rose(pinIn_q[1]));
    c_unmapped_error: cover property (apbRsp.pready && apbRsp.pslverr);

endmodule

//--- test/misc_peripheral_control_regs_bench.sv
// Self-checking bench for the misc control bank, one task per scenario.
// Assumes the package and the design core are compiled first; no partner.
`timescale 1ns/10ps

module misc_peripheral_control_regs_bench;
    import misc_ctrl_pkg::*;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clockEnable = 1'b1;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    logic [1:0] generalPinIn = 2'h0;
    logic [1:0] generalPinOut;
    logic [1:0] generalPinOe_n;
    logic [1:0] dacEnable = 2'h0;
    logic clockSourceSelectPin = 1'b1;
    logic clockPinOe_n;
    logic oscillatorHalt;
    logic cpuHalt;
    analog_ctrl_t analogCtrl;
    int numErrors = 0;
    int nTests = 0;
    logic [7:0] regIdx [8] = '{IDX_TIMER_CONTROL, IDX_TIMER_SETUP,
        IDX_BUFFER_CONFIG, IDX_POWER, IDX_OSCILLATOR, IDX_EXCITATION,
        IDX_PIN_ONE, IDX_PIN_TWO};
    int powBit [6] = '{12, 8, 5, 4, 1, 0};

    misc_peripheral_control_regs i_dut (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .generalPinIn(generalPinIn),
        .generalPinOut(generalPinOut),
        .generalPinOe_n(generalPinOe_n),
        .dacEnable(dacEnable),
        .clockSourceSelectPin(clockSourceSelectPin),
        .clockPinOe_n(clockPinOe_n),
        .oscillatorHalt(oscillatorHalt),
        .cpuHalt(cpuHalt),
        .analogCtrl(analogCtrl)
    );

    always #25 clock = ~clock;

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the whole request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [15:0] d, output logic [15:0] q,
                       output logic e);
        @(posedge clock);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= w;
        apbReq.paddr <= a;
        apbReq.pwdata <= {16'h0000, d};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        @(posedge clock);
        // No local limit: a hung slave is caught by the watchdog
        while (apbRsp.pready !== 1'b1) begin
            @(posedge clock);
        end
        q = apbRsp.prdata[15:0];
        e = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input string what, input logic [11:0] a,
                      input logic [15:0] exp);
        logic [15:0] q;
        logic e;
        apb(1'b0, a, 16'h0000, q, e);
        chk(what, {16'h0000, exp}, {16'h0000, q});
    endtask

    // Lets registered outputs land before they are looked at
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic pulse(input int p, input int n);
        @(posedge clock);
        generalPinIn[p] <= 1'b1;
        repeat (n) @(posedge clock);
        generalPinIn[p] <= 1'b0;
    endtask

    task automatic testRegs;
        logic [15:0] q;
        logic e;
        for (int i = 0; i < 8; i++) rd("reset value", ba(regIdx[i]), REG_RESET);
        wr(ba(IDX_TIMER_CONTROL), 16'h8000);
        rd("done read only", ba(IDX_TIMER_CONTROL), 16'h0000);
        wr(ba(IDX_BUFFER_CONFIG), 16'hFFFF);
        rd("buffer mask", ba(IDX_BUFFER_CONFIG), 16'h0003);
        wr(ba(IDX_POWER), 16'hFFFF);
        rd("power mask", ba(IDX_POWER), 16'h1133);
        wr(ba(IDX_OSCILLATOR), 16'hFFFF);
        rd("osc mask", ba(IDX_OSCILLATOR), 16'h1F01);
        wr(ba(IDX_EXCITATION), 16'hFFFF);
        rd("excitation mask", ba(IDX_EXCITATION), 16'h0007);
        wr(ba(IDX_TIMER_SETUP), 16'hFFFF);
        rd("setup fields", ba(IDX_TIMER_SETUP), 16'hFFFF);
        settle(2);
        chk("analog all", 32'h0000FFFF, 32'(analogCtrl));
        apb(1'b0, 12'h0F0, 16'h0000, q, e);
        chk("unmapped err", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, 32'(q));
        for (int b = 0; b < 6; b++) begin
            wr(ba(IDX_POWER), 16'(1 << powBit[b]));
            settle(2);
            chk("power map", 32'h20 >> b, 32'(analogCtrl[15:10]));
        end
        wr(ba(IDX_BUFFER_CONFIG), 16'h0002);
        wr(ba(IDX_POWER), 16'h0000);
        wr(ba(IDX_EXCITATION), 16'h0005);
        wr(ba(IDX_OSCILLATOR), 16'h1000);
        settle(2);
        chk("buffer map", 32'h2, 32'(analogCtrl[9:8]));
        chk("current code", 32'h5, 32'(analogCtrl.excitationCurrentCode));
        chk("trim low", 32'hFFFFFFF0, 32'(analogCtrl.oscillatorTrim));
        wr(ba(IDX_OSCILLATOR), 16'h0F00);
        settle(2);
        chk("trim high", 32'h0F, 32'(analogCtrl.oscillatorTrim));
        wr(ba(IDX_BUFFER_CONFIG), 16'h0000);
        $display("Test registers done");
    endtask

    task automatic testDac;
        for (int v = 1; v < 4; v++) begin
            @(posedge clock);
            dacEnable <= 2'(v);
            settle(3);
            chk("dac override", 32'(v[1] * 5'h0A + v[0] * 5'h05),
                {28'h0, analogCtrl[11:8]});
        end
        // Enable low must freeze the outputs at the last forced value
        @(posedge clock);
        clockEnable <= 1'b0;
        dacEnable <= 2'h0;
        settle(3);
        chk("enable low freezes", 32'hF, 32'(analogCtrl[11:8]));
        @(posedge clock);
        clockEnable <= 1'b1;
        settle(3);
        chk("dac released", 32'h0, 32'(analogCtrl[11:8]));
        $display("Test converter override done");
    endtask

    task automatic testPins;
        logic [11:0] a;
        for (int p = 0; p < 2; p++) begin
            a = p ? ba(IDX_PIN_TWO) : ba(IDX_PIN_ONE);
            wr(a, 16'h0030);
            settle(2);
            chk("pin drive", 32'h1, {31'h0, generalPinOut[p] & ~generalPinOe_n[p]});
            wr(a, 16'h0000);
            settle(2);
            chk("pin released", 32'h1, 32'(generalPinOe_n[p]));
            @(posedge clock);
            generalPinIn[p] <= 1'b1;
            settle(12);
            rd("level high", a, 16'h0008);
            wr(a, 16'h0002);
            settle(4);
            rd("level invert", a, 16'h0002);
            wr(a, 16'h0000);
            @(posedge clock);
            generalPinIn[p] <= 1'b0;
            @(posedge clock);
            generalPinIn[p] <= 1'b1;
            settle(12);
            rd("short low ignored", a, 16'h0008);
            @(posedge clock);
            generalPinIn[p] <= 1'b0;
            settle(12);
            wr(a, 16'h0005);
            wr(a, 16'h0001);
            rd("edge cleared", a, 16'h0001);
            pulse(p, 3);
            settle(12);
            rd("short pulse ignored", a, 16'h0001);
            pulse(p, 6);
            settle(12);
            rd("rising captured", a, 16'h0009);
            wr(a, 16'h0005);
            pulse(p, 6);
            settle(12);
            rd("clear blocks", a, 16'h0005);
            wr(a, 16'h0003);
            @(posedge clock);
            generalPinIn[p] <= 1'b1;
            settle(12);
            rd("rising ignored", a, 16'h0003);
            @(posedge clock);
            generalPinIn[p] <= 1'b0;
            settle(12);
            rd("falling captured", a, 16'h000B);
            wr(a, 16'h0000);
        end
        $display("Test pins done");
    endtask

    task automatic testTimer;
        int n;
        int k;
        for (int c = 0; c < 16; c++) begin
            n = 0;
            k = 0;
            wr(ba(IDX_TIMER_SETUP), {4'(c), 12'h002});
            wr(ba(IDX_TIMER_CONTROL), 16'h4001);
            @(posedge clock);
            while (cpuHalt !== 1'b1 && k < 10) begin
                k++;
                @(posedge clock);
            end
            while (cpuHalt === 1'b1 && n < 1000) begin
                n++;
                @(posedge clock);
            end
            chk("halt span", (((c % 2) ? 3 : 1) << (c / 2)) * 2, n);
            rd("timer done", ba(IDX_TIMER_CONTROL), 16'h8001);
        end
        wr(ba(IDX_TIMER_SETUP), 16'hF001);
        wr(ba(IDX_TIMER_CONTROL), 16'h4000);
        rd("start clears done", ba(IDX_TIMER_CONTROL), 16'h4000);
        chk("no halt", 32'h0, 32'(cpuHalt));
        settle(400);
        rd("long done", ba(IDX_TIMER_CONTROL), 16'h8000);
        $display("Test timer done");
    endtask

    task automatic testClockPin;
        wr(ba(IDX_OSCILLATOR), 16'h0001);
        settle(3);
        chk("clock out on", 32'h0, 32'({clockPinOe_n, oscillatorHalt}));
        wr(ba(IDX_OSCILLATOR), 16'h0000);
        settle(3);
        chk("clock out off", 32'h2, 32'({clockPinOe_n, oscillatorHalt}));
        wr(ba(IDX_OSCILLATOR), 16'h0001);
        @(posedge clock);
        clockSourceSelectPin <= 1'b0;
        settle(6);
        chk("strap low", 32'h3, 32'({clockPinOe_n, oscillatorHalt}));
        @(posedge clock);
        clockSourceSelectPin <= 1'b1;
        settle(6);
        chk("strap high", 32'h0, 32'({clockPinOe_n, oscillatorHalt}));
        $display("Test clock pin done");
    endtask

    task automatic endOfTest;
        $display("Comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        testRegs();
        testDac();
        testPins();
        testTimer();
        testClockPin();
        endOfTest();
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge clock);
        numErrors++;
        endOfTest();
    end
endmodule
